/* pkg/dcrs_map.vh */
// constants for the disk cache read sequencer
`ifndef DCRS_MAP_VH
`define DCRS_MAP_VH
`define DCRS_OP_RD_HA      8'h1A
`define DCRS_OP_RD_HA_MT   8'h9A
`define DCRS_OP_RD_TDR     8'h16
`define DCRS_OP_RD_TDR_MT  8'h96
`define DCRS_OP_RD_CNT     8'h12
`define DCRS_OP_RD_CNT_MT  8'h92
`define DCRS_OP_RD_DATA    8'h06
`define DCRS_OP_RD_DATA_MT 8'h86
`define DCRS_OP_RD_KD      8'h0E
`define DCRS_OP_RD_KD_MT   8'h8E
`define DCRS_OP_RD_CKD     8'h1E
`define DCRS_OP_RD_CKD_MT  8'h9E
`define DCRS_OP_RD_MULTI   8'h5E
`define DCRS_OP_RD_LOAD    8'h02
`define DCRS_OP_RD_SECTOR  8'h22
`define DCRS_OP_SPACE_CNT  8'h0F
`define DCRS_OP_SEARCH_MSK 8'h31
`define DCRS_HA_LEN        16'h0005
`define DCRS_CNT_LEN       16'h0008
`define DCRS_GAP2          2'h2
`define DCRS_GAP3          2'h3
`define DCRS_SLOT_EMPTY    2'h0
`define DCRS_SLOT_FULL     2'h1
`define DCRS_SLOT_PARTIAL  2'h2
`define DCRS_SLOT_TWO_PART 2'h3
`define DCRS_LOAD_REC      8'h01
`endif

/* src/dcrs_seq.v */
// disk cache read sequencer: command decode, tag sequencing, cache hit/miss
`timescale 1ns/1ns
`default_nettype none
`include "dcrs_map.vh"
module dcrs_seq (
    // clock and reset
    input  wire        clk_sys_in,
    input  wire        srst_in,
    // channel command side
    input  wire        cmd_valid_in,
    input  wire [7:0]  cmd_op_in,
    input  wire        cmd_chained_in,
    input  wire        chain_has_search_in,
    input  wire        chain_has_write_in,
    output reg         cmd_busy_out,
    output reg         chan_end_out,
    output reg         dev_end_out,
    output reg         unit_check_out,
    output reg         cmd_reject_out,
    output reg         cmd_retry_out,
    // channel data
    output reg         chan_valid_out,
    output reg  [7:0]  chan_data_out,
    // disk side (pins, synchronised)
    input  wire        disk_valid_in,
    input  wire [7:0]  disk_data_in,
    input  wire        disk_index_in,
    input  wire        disk_area_end_in,
    input  wire [7:0]  disk_rec_in,
    input  wire        disk_last_rec_in,
    input  wire        disk_ecc_bad_in,
    output reg         disk_tag_out,
    output reg  [1:0]  disk_gap_out,
    // cache side
    input  wire        cache_track_hit_in,
    input  wire        cache_rec_hit_in,
    input  wire [1:0]  cache_slot_form_in,
    input  wire        cache_valid_in,
    input  wire [7:0]  cache_data_in,
    input  wire        cache_area_end_in,
    input  wire        cache_last_rec_in,
    input  wire        cache_ha_pos_in,
    output reg         cache_rd_out,
    output reg         cache_wr_out,
    output reg  [7:0]  cache_wr_data_out,
    output reg         cache_mru_out,
    output reg         cache_append_out
);
    // ==========================================================
    // states
    localparam [3:0] ST_IDLE = 4'h0, ST_TAG = 4'h1, ST_GAP = 4'h2, ST_CNT = 4'h3,
                     ST_KEY = 4'h4, ST_DATA = 4'h5, ST_END = 4'h6, ST_ORIENT = 4'h7,
                     ST_PROMO = 4'h8, ST_HA = 4'h9, ST_SKIP = 4'hA;
    // ==========================================================
    // input synchronisers for disk pins
    reg [12:0] dsk_s1_reg, dsk_s2_reg;
    reg [7:0]  dd_s1_reg, dd_s2_reg, dr_s1_reg, dr_s2_reg;
    always @(posedge clk_sys_in) begin
        dsk_s1_reg <= {disk_valid_in, disk_index_in, disk_area_end_in, disk_last_rec_in,
                       disk_ecc_bad_in, 8'h00};
        dsk_s2_reg <= dsk_s1_reg;
        dd_s1_reg  <= disk_data_in;
        dd_s2_reg  <= dd_s1_reg;
        dr_s1_reg  <= disk_rec_in;
        dr_s2_reg  <= dr_s1_reg;
    end
    wire d_valid = dsk_s2_reg[12];
    wire d_index = dsk_s2_reg[11];
    wire d_aend  = dsk_s2_reg[10];
    wire d_last  = dsk_s2_reg[9];
    wire d_ecc   = dsk_s2_reg[8];
    // ==========================================================
    // opcode decode
    function [3:0] dcrs_kind;
        input [7:0] op;
        begin
            if (op == `DCRS_OP_RD_HA || op == `DCRS_OP_RD_HA_MT) dcrs_kind = 4'h1;
            else if (op == `DCRS_OP_RD_TDR || op == `DCRS_OP_RD_TDR_MT) dcrs_kind = 4'h2;
            else if (op == `DCRS_OP_RD_CNT || op == `DCRS_OP_RD_CNT_MT) dcrs_kind = 4'h3;
            else if (op == `DCRS_OP_RD_DATA || op == `DCRS_OP_RD_DATA_MT) dcrs_kind = 4'h4;
            else if (op == `DCRS_OP_RD_KD || op == `DCRS_OP_RD_KD_MT) dcrs_kind = 4'h5;
            else if (op == `DCRS_OP_RD_CKD || op == `DCRS_OP_RD_CKD_MT) dcrs_kind = 4'h6;
            else if (op == `DCRS_OP_RD_MULTI) dcrs_kind = 4'h7;
            else if (op == `DCRS_OP_RD_LOAD) dcrs_kind = 4'h8;
            else dcrs_kind = 4'h0;
        end
    endfunction
    localparam [3:0] K_HA = 4'h1, K_TDR = 4'h2, K_CNT = 4'h3, K_DATA = 4'h4, K_KD = 4'h5,
                     K_CKD = 4'h6, K_MULTI = 4'h7, K_LOAD = 4'h8;
    // ==========================================================
    // sequencer registers
    reg [3:0] state_reg;
    reg [3:0] kind_reg;
    reg       from_cache_reg;   // serving from cache
    reg       fill_reg;         // copying to cache while reading disk
    reg       after_cnt_reg;    // last command left us past a count area
    reg       wrapped_reg;      // index passed during this command
    wire [3:0] k_in = dcrs_kind(cmd_op_in);
    // read chain: search plus read, no write; load and space never promote
    wire read_chain = chain_has_search_in && !chain_has_write_in;
    wire promo_ok   = read_chain && (k_in != K_LOAD);
    wire src_valid  = from_cache_reg ? cache_valid_in : d_valid;
    wire [7:0] src_data = from_cache_reg ? cache_data_in : dd_s2_reg;
    wire src_aend   = from_cache_reg ? cache_area_end_in : d_aend;
    wire src_last   = from_cache_reg ? cache_last_rec_in : d_last;
    wire moving = (state_reg == ST_HA) || (state_reg == ST_CNT) || (state_reg == ST_KEY)
                  || (state_reg == ST_DATA);
    wire zero_rec = (dr_s2_reg == 8'h00);
    // ==========================================================
    // main state machine
    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            // every output and state bit low in reset
            state_reg         <= ST_IDLE;
            kind_reg          <= 4'h0;
            from_cache_reg    <= 1'b0;
            fill_reg          <= 1'b0;
            after_cnt_reg     <= 1'b0;
            wrapped_reg       <= 1'b0;
            cmd_busy_out      <= 1'b0;
            chan_end_out      <= 1'b0;
            dev_end_out       <= 1'b0;
            unit_check_out    <= 1'b0;
            cmd_reject_out    <= 1'b0;
            cmd_retry_out     <= 1'b0;
            chan_valid_out    <= 1'b0;
            chan_data_out     <= 8'h00;
            disk_tag_out      <= 1'b0;
            disk_gap_out      <= 2'h0;
            cache_rd_out      <= 1'b0;
            cache_wr_out      <= 1'b0;
            cache_wr_data_out <= 8'h00;
            cache_mru_out     <= 1'b0;
            cache_append_out  <= 1'b0;
        end else begin
            // pulses fall back low unless set below
            chan_end_out   <= 1'b0;
            dev_end_out    <= 1'b0;
            unit_check_out <= 1'b0;
            cmd_reject_out <= 1'b0;
            cmd_retry_out  <= 1'b0;
            chan_valid_out <= 1'b0;
            disk_tag_out   <= 1'b0;
            cache_wr_out   <= 1'b0;
            cache_mru_out  <= 1'b0;

            // data move to channel, and concurrent fill of cache on a miss
            if (moving && src_valid) begin
                chan_valid_out    <= 1'b1;
                chan_data_out     <= src_data;
                cache_wr_out      <= fill_reg;
                cache_wr_data_out <= src_data;
            end

            case (state_reg)
            ST_IDLE: begin
                // no prerequisite command is ever checked
                if (cmd_valid_in) begin
                    kind_reg     <= k_in;
                    cmd_busy_out <= 1'b1;
                    wrapped_reg  <= 1'b0;
                    if (k_in == 4'h0) begin
                        // unknown opcode: ending status with reject at once
                        chan_end_out   <= 1'b1;
                        dev_end_out    <= 1'b1;
                        unit_check_out <= 1'b1;
                        cmd_reject_out <= 1'b1;
                        cmd_busy_out   <= 1'b0;
                    end else if (promo_ok && cache_track_hit_in && !cache_rec_hit_in
                                 && cache_slot_form_in == `DCRS_SLOT_PARTIAL) begin
                        // partial slot without the record: retry, then promote
                        cmd_retry_out  <= 1'b1;
                        from_cache_reg <= 1'b0;
                        fill_reg       <= 1'b0;
                        state_reg      <= ST_ORIENT;
                    end else begin
                        // read-chain hit on a non-empty slot: cache only; otherwise disk, copied only on a read-chain miss other than load
                        from_cache_reg <= cache_track_hit_in && read_chain
                                          && cache_slot_form_in != `DCRS_SLOT_EMPTY;
                        fill_reg       <= promo_ok && !cache_track_hit_in;
                        cache_rd_out   <= cache_track_hit_in && read_chain;
                        cache_mru_out  <= cache_track_hit_in;
                        state_reg      <= ST_TAG;
                    end
                end
            end

            ST_TAG: begin
                // one disk tag per command read from disk, plus one per further record for read multiple;
                // a read-chain hit on a non-empty slot, or a promoted track, sends no tag and goes from here straight to an area state, not to the gap state
                disk_tag_out <= !from_cache_reg;
                if (kind_reg == K_HA || kind_reg == K_TDR) begin
                    disk_gap_out <= 2'h0;
                    state_reg    <= ST_HA;
                end else if (kind_reg == K_DATA || kind_reg == K_KD
                             || kind_reg == K_LOAD) begin
                    disk_gap_out <= `DCRS_GAP2;
                    if (from_cache_reg)
                        state_reg <= (kind_reg == K_KD) ? ST_KEY : ST_DATA;
                    else
                        state_reg <= ST_GAP;
                end else begin
                    disk_gap_out <= `DCRS_GAP3;
                    state_reg    <= from_cache_reg ? ST_CNT : ST_GAP;
                end
            end

            ST_GAP: begin
                // clock over the gap; record zero runs past whole
                if (src_aend) begin
                    if (after_cnt_reg && disk_gap_out == `DCRS_GAP2) begin
                        // chained from a count: same record, no record test
                        state_reg <= (kind_reg == K_KD) ? ST_KEY : ST_SKIP;
                    end else if (!zero_rec) begin
                        if (kind_reg == K_LOAD && dr_s2_reg != `DCRS_LOAD_REC)
                            state_reg <= ST_GAP;
                        else if (disk_gap_out == `DCRS_GAP2)
                            state_reg <= (kind_reg == K_KD) ? ST_KEY : ST_SKIP;
                        else
                            state_reg <= ST_CNT;
                    end
                end
                if (d_index) wrapped_reg <= 1'b1;
            end

            // key area clocked over without sending it
            ST_SKIP: if (src_aend) state_reg <= ST_DATA;

            ST_HA: if (src_aend) begin
                if (kind_reg == K_HA) begin
                    unit_check_out <= d_ecc && !from_cache_reg;
                    state_reg      <= ST_END;
                end else state_reg <= ST_CNT;
            end

            ST_CNT: if (src_aend) begin
                after_cnt_reg <= 1'b1;
                state_reg     <= (kind_reg == K_CNT) ? ST_END : ST_KEY;
            end

            ST_KEY: if (src_aend) state_reg <= ST_DATA;

            ST_DATA: if (src_aend) begin
                after_cnt_reg <= 1'b0;
                if (kind_reg == K_MULTI && !src_last) begin
                    disk_tag_out <= !from_cache_reg;
                    disk_gap_out <= `DCRS_GAP3;
                    state_reg    <= ST_GAP;
                end else state_reg <= ST_END;
            end

            ST_END: begin
                // channel end and device end together, then idle
                chan_end_out <= 1'b1;
                dev_end_out  <= 1'b1;
                cmd_busy_out <= 1'b0;
                cache_rd_out <= 1'b0;
                fill_reg     <= 1'b0;
                if (!cmd_chained_in) after_cnt_reg <= 1'b0;
                state_reg    <= ST_IDLE;
            end

            ST_ORIENT: if (d_index) begin
                cache_append_out <= 1'b1;
                fill_reg         <= 1'b1;
                state_reg        <= ST_PROMO;
            end

            ST_PROMO: begin
                // copy from home address up to the cached partial image
                if (d_valid) begin
                    cache_wr_out      <= 1'b1;
                    cache_wr_data_out <= dd_s2_reg;
                end
                if (cache_ha_pos_in) begin
                    cache_append_out <= 1'b0;
                    fill_reg         <= 1'b0;
                    from_cache_reg   <= 1'b1;
                    cache_rd_out     <= 1'b1;
                    cache_mru_out    <= 1'b1;
                    state_reg        <= ST_TAG;
                end
            end

            default: state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule // dcrs_seq
`default_nettype wire

/* dv/dcrs_seq_asserts.sv */
// port checks for the disk cache read sequencer
`timescale 1ns/1ns
`default_nettype none
`include "dcrs_map.vh"
module dcrs_seq_chk (
    // watched ports
    input wire logic       clk_sys_in, srst_in, cmd_valid_in, chain_has_search_in,
    input wire logic [7:0] cmd_op_in,
    input wire logic       cache_track_hit_in, cache_rec_hit_in, cmd_busy_out,
    input wire logic [1:0] cache_slot_form_in, disk_gap_out,
    input wire logic       chan_end_out, dev_end_out, unit_check_out, cmd_reject_out,
    input wire logic       cmd_retry_out, disk_tag_out, cache_rd_out, cache_mru_out
);
    // ==========
    // assertions
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);
    wire logic take = cmd_valid_in && !cmd_busy_out;
    wire logic miss = take && !cache_track_hit_in;
    wire logic hit  = take && cache_track_hit_in && chain_has_search_in;
    a_reject_status: assert property (take && cmd_op_in == 8'hFF
        |-> ##[1:2] unit_check_out && cmd_reject_out) else $error("no reject status");
    a_count_gap: assert property (miss && cmd_op_in == `DCRS_OP_RD_CNT
        |-> ##[1:4] disk_tag_out && disk_gap_out == `DCRS_GAP3) else $error("no gap 3 tag");
    a_data_gap: assert property (miss && cmd_op_in == `DCRS_OP_RD_DATA
        |-> ##[1:4] disk_tag_out && disk_gap_out == `DCRS_GAP2) else $error("no gap 2 tag");
    a_hit_no_disk: assert property (cache_rd_out |-> !disk_tag_out)
        else $error("disk tag while serving cache");
    a_hit_mru: assert property (hit && cache_rec_hit_in
        && cmd_op_in == `DCRS_OP_RD_CNT |-> ##[1:3] cache_mru_out) else $error("no mru mark");
    a_partial_retry: assert property (hit && !cache_rec_hit_in
        && cache_slot_form_in == `DCRS_SLOT_PARTIAL && cmd_op_in == `DCRS_OP_RD_CNT
        |-> ##[1:4] cmd_retry_out) else $error("no retry on partial slot");
    a_end_paired: assert property (chan_end_out && !unit_check_out |-> dev_end_out)
        else $error("channel end without device end");
    a_end_idle: assert property (dev_end_out |=> !cmd_busy_out)
        else $error("busy after end status");
    c_retry: cover property (cmd_retry_out);
    c_served: cover property (cache_rd_out && cache_mru_out);
    c_reject: cover property (cmd_reject_out);
endmodule // dcrs_seq_chk
bind dcrs_seq dcrs_seq_chk u_chk (.clk_sys_in, .srst_in, .cmd_valid_in, .chain_has_search_in,
    .cmd_op_in, .cache_track_hit_in, .cache_rec_hit_in, .cmd_busy_out, .cache_slot_form_in,
    .disk_gap_out, .chan_end_out, .dev_end_out, .unit_check_out, .cmd_reject_out,
    .cmd_retry_out, .disk_tag_out, .cache_rd_out, .cache_mru_out);
`default_nettype wire

/* dv/dcrs_disk_model.sv */
// behavioural disk drive answering gap tags with record areas
`timescale 1ns/1ns
`default_nettype none
module dcrs_disk_model (
    // tag side
    input  wire logic       clk_sys_in, srst_in, disk_tag_out,
    input  wire logic [1:0] disk_gap_out,
    // disk pins
    output logic            disk_valid_in, disk_area_end_in, disk_last_rec_in,
    output logic [7:0]      disk_data_in, disk_rec_in
);
    logic [7:0] rec_n = 8'h00;
    int         a;
    int         k;
    assign disk_last_rec_in = (disk_rec_in == 8'h0F);
    // gap end, key (gap two only), then count or data; record zero runs on
    initial begin
        {disk_valid_in, disk_area_end_in, disk_data_in, disk_rec_in} = 18'h0;
        forever begin
            @(posedge clk_sys_in);
            disk_data_in <= ~disk_data_in; // idle bus never holds a value
            if (srst_in) rec_n <= 8'h00;
            else if (disk_tag_out === 1'b1) begin
                do begin
                    repeat (3) @(posedge clk_sys_in);
                    disk_rec_in <= rec_n;
                    // gap end always; key only behind gap two; then count or data
                    for (a = -1; a < 2; a++) begin
                        if (a == 0 && disk_gap_out != 2'h2) continue;
                        for (k = 0; k < (a == 0 ? 2 : a * 8); k++) begin
                            disk_valid_in <= 1'b1;
                            disk_data_in <= {rec_n[3:0], a[0], k[2:0]};
                            @(posedge clk_sys_in);
                        end
                        disk_valid_in <= 1'b0;
                        disk_area_end_in <= 1'b1;
                        @(posedge clk_sys_in);
                        disk_area_end_in <= 1'b0;
                    end
                    rec_n <= rec_n + 8'h01;
                end while (disk_rec_in == 8'h00);
            end
        end
    end
endmodule // dcrs_disk_model
`default_nettype wire

/* dv/dcrs_seq_bench.sv */
// self-checking bench for the disk cache read sequencer
`timescale 1ns/1ns
`default_nettype none
`include "dcrs_map.vh"
module dcrs_seq_bench;
    logic       clk_sys_in = 1'b0, srst_in = 1'b1, cmd_valid_in = 1'b0, cache_valid_in = 1'b0;
    logic       chain_has_search_in = 1'b1, chain_has_write_in = 1'b0, cache_area_end_in = 1'b0;
    logic       cache_track_hit_in = 1'b0, cache_rec_hit_in = 1'b0;
    logic [7:0] cmd_op_in = 8'h00, cache_data_in = 8'h00, first_byte, ops [4];
    logic [1:0] cache_slot_form_in = 2'h0;
    logic       got_chk = 1'b0, got_retry = 1'b0, got_mru = 1'b0, got_end = 1'b0;
    wire logic  cmd_busy_out, chan_end_out, dev_end_out, unit_check_out, cmd_reject_out;
    wire logic  cmd_retry_out, chan_valid_out, disk_tag_out, cache_rd_out, cache_wr_out;
    wire logic  cache_mru_out, cache_append_out, disk_valid_in, disk_area_end_in, disk_last_rec_in;
    wire logic [7:0] chan_data_out, disk_data_in, disk_rec_in, cache_wr_data_out;
    wire logic [1:0] disk_gap_out;
    int         fail_count = 0, comparisons = 0, nbytes = 0, nwr = 0, ntag = 0, cpos = 0, rec = 1;
    dcrs_seq dut (.clk_sys_in, .srst_in, .cmd_valid_in, .cmd_op_in, .cmd_chained_in(1'b0),
        .chain_has_search_in, .chain_has_write_in, .cmd_busy_out, .chan_end_out, .dev_end_out,
        .unit_check_out, .cmd_reject_out, .cmd_retry_out, .chan_valid_out, .chan_data_out,
        .disk_valid_in, .disk_data_in, .disk_index_in(1'b0), .disk_area_end_in, .disk_rec_in,
        .disk_last_rec_in, .disk_ecc_bad_in(1'b0), .disk_tag_out, .disk_gap_out,
        .cache_track_hit_in, .cache_rec_hit_in, .cache_slot_form_in, .cache_valid_in,
        .cache_data_in, .cache_area_end_in, .cache_last_rec_in(1'b0), .cache_ha_pos_in(1'b0),
        .cache_rd_out, .cache_wr_out, .cache_wr_data_out, .cache_mru_out, .cache_append_out);
    dcrs_disk_model disk (.clk_sys_in, .srst_in, .disk_tag_out, .disk_gap_out, .disk_valid_in,
        .disk_area_end_in, .disk_data_in, .disk_rec_in, .disk_last_rec_in);
    always #50 clk_sys_in = ~clk_sys_in;
    // tally and cache slot answering a served read with eight bytes
    always @(posedge clk_sys_in) begin
        if (chan_valid_out === 1'b1 && nbytes == 0) first_byte <= chan_data_out;
        nbytes <= nbytes + (chan_valid_out === 1'b1);
        nwr <= nwr + (cache_wr_out === 1'b1);
        ntag <= ntag + (disk_tag_out === 1'b1);
        got_chk <= got_chk | (unit_check_out === 1'b1 && cmd_reject_out === 1'b1);
        got_retry <= got_retry | (cmd_retry_out === 1'b1);
        got_mru <= got_mru | (cache_mru_out === 1'b1);
        got_end <= got_end | ((dev_end_out | unit_check_out | cmd_retry_out) === 1'b1);
        cache_valid_in <= cache_rd_out === 1'b1 && cpos < 8;
        cache_area_end_in <= cache_rd_out === 1'b1 && cpos == 8;
        cache_data_in <= (cache_rd_out === 1'b1) ? 8'hC0 + cpos[7:0] : ~cache_data_in;
        if (cache_rd_out === 1'b1) cpos <= cpos + 1;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // one command, waiting a bounded time for its ending status
    task automatic issue(input logic [7:0] op);
        @(negedge clk_sys_in);
        {got_chk, got_retry, got_mru, got_end} = 4'h0;
        {nbytes, nwr, ntag, cpos} = 128'h0;
        @(posedge clk_sys_in);
        cmd_valid_in <= 1'b1;
        cmd_op_in <= op;
        @(posedge clk_sys_in);
        cmd_valid_in <= 1'b0;
        for (int c = 0; c < 600 && got_end !== 1'b1; c++) @(posedge clk_sys_in);
        if (got_end !== 1'b1) begin
            check(got_end, 1, "no ending status");
            stop_test;
        end
        repeat (2) @(posedge clk_sys_in);
    endtask
    task automatic t_reject;
        issue(8'hFF);
        check(got_chk, 1, "reject status");
        check(nbytes, 0, "reject sent data");
        $display("reject test done");
    endtask
    // count reads on a miss, both opcodes, then one inside a write chain
    task automatic t_count;
        ops = '{`DCRS_OP_RD_CNT, `DCRS_OP_RD_CNT_MT, `DCRS_OP_RD_CNT, 8'h00};
        for (int i = 0; i < 3; i++) begin
            chain_has_write_in <= (i == 2);
            issue(ops[i]);
            check(nbytes, 8, "count length");
            check(first_byte, {rec[3:0], 4'h8}, "count record");
            check(ntag, 1, "one gap tag");
            check(nwr != 0, i != 2, "cache copy on miss");
            rec++;
        end
        $display("count test done");
    endtask
    task automatic t_data;
        ops = '{`DCRS_OP_RD_DATA, `DCRS_OP_RD_DATA_MT, `DCRS_OP_RD_KD, `DCRS_OP_RD_KD_MT};
        for (int i = 0; i < 4; i++) begin
            issue(ops[i]);
            check(nbytes, (i < 2) ? 8 : 10, "data length");
            check(first_byte, {rec[3:0], (i < 2) ? 4'h8 : 4'h0}, "key skip");
            rec++;
        end
        $display("data test done");
    endtask
    task automatic t_hit;
        chain_has_write_in <= 1'b0;
        cache_track_hit_in <= 1'b1;
        cache_rec_hit_in <= 1'b1;
        cache_slot_form_in <= `DCRS_SLOT_FULL;
        issue(`DCRS_OP_RD_CNT);
        check(ntag, 0, "disk used on hit");
        check({nbytes[7:0], first_byte}, 16'h08C0, "cache bytes");
        check(got_mru, 1, "most recent mark");
        $display("hit test done");
    endtask
    task automatic t_partial;
        cache_rec_hit_in <= 1'b0;
        cache_slot_form_in <= `DCRS_SLOT_PARTIAL;
        issue(`DCRS_OP_RD_CNT);
        check(got_retry, 1, "retry on partial");
        check(nbytes, 0, "data before promotion");
        $display("partial test done");
    endtask
    initial begin
        repeat (3) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        t_reject;
        t_count;
        t_data;
        t_hit;
        t_partial;
        stop_test;
    end
endmodule // dcrs_seq_bench
`default_nettype wire
